// ---- logic/bam_register_map.sv ----
// serial-port register bank of the bridge converter
// Overview of operation
// R1: every register is reached only through the serial data, clock and select pins.
// R2: each access starts with a write of the command byte, which never reads back.
// R3: the command byte chooses read or write and the register for the next transfer.
// R4: a single transfer returns to command mode, continuous read stays on its register.
// R5: the status byte shows ready, settling, standby, reference and mode state.
// R6: the result register holds the latest conversion and resets to zero.
// R7: the result is read as 16 or 24 bits by the word length bit of the setup word.
// R8: the 16-bit setup word holds mode, coding, pin, burnout, length, clock, reference, range and channel.
// R9: the 24-bit averaging word holds the averaging count and the step, skip, drive, chop and delay controls.
// R10: the tare byte keeps a 6-bit correction and its two upper bits stay zero.
// R11: three 24-bit zero coefficients exist, one chosen by the channel.
// R12: three 24-bit scale coefficients exist, one chosen by the channel.
// R13: the host should leave the diagnostic word at its default.
// R14: thirty-two serial clocks with data high reset the bank to command mode.
// R15: kind codes 00 write, 01 read, 10 start continuous read, 11 stop it.
// R16: all registers take their defaults at reset before any access.
module bam_register_map #(
  parameter int COEF_SETS = 3
) (
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic din_i,
  input wire logic cs_n_i,
  output logic dout_o,
  output logic dout_oe_o,
  input wire logic [23:0] result_i,
  input wire logic result_load_i,
  input wire logic step_unsettled_i,
  input wire logic standby_flag_i,
  input wire logic reference_missing_flag_i,
  output logic [15:0] setup_o,
  output logic [23:0] averaging_o,
  output logic [7:0] tare_o,
  output logic [23:0] zero_coef_o,
  output logic [23:0] scale_coef_o,
  output logic [23:0] diag_o
);

  if (COEF_SETS < 1 || COEF_SETS > 4) begin : g_check
    $error("COEF_SETS must be 1 to 4");
  end

  // ************************************************************
  // pin synchronisers and edge detection
  // ************************************************************
  logic [2:0] pin_meta;
  logic sclk_sync, din_sync, cs_n_sync, sclk_prev;

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      pin_meta <= 3'h7;
      sclk_sync <= 1'b1;
      din_sync <= 1'b1;
      cs_n_sync <= 1'b1;
      sclk_prev <= 1'b1;
    end else begin
      pin_meta <= {sclk_i, din_i, cs_n_i};
      sclk_sync <= pin_meta[2];
      din_sync <= pin_meta[1];
      cs_n_sync <= pin_meta[0];
      sclk_prev <= sclk_sync;
    end
  end

  logic rise, fall;
  assign rise = sclk_sync & ~sclk_prev & ~cs_n_sync; // R1
  assign fall = ~sclk_sync & sclk_prev & ~cs_n_sync;

  // ************************************************************
  // transfer sequencing
  // ************************************************************
  bam_pkg::bam_state_e state;
  logic [2:0] sel;
  logic cont;
  logic [4:0] bit_cnt;
  logic [23:0] rx_shift, tx_shift;
  logic [5:0] ones_cnt;
  logic [15:0] setup;
  logic [23:0] avg, diag, result;
  logic [7:0] tare;
  logic not_ready;
  logic [23:0] zero_coef [COEF_SETS];
  logic [23:0] scale_coef [COEF_SETS];

  function automatic logic [1:0] chan_idx(input logic [15:0] s);
    logic [1:0] ch;
    ch = s[bam_pkg::SETUP_CH_HI:bam_pkg::SETUP_CH_LO];
    chan_idx = (int'(ch) >= COEF_SETS) ? 2'(COEF_SETS - 1) : ch;
  endfunction : chan_idx

  logic [23:0] rx_next;
  logic [7:0] cmd_next;
  logic [1:0] cmd_kind;
  logic [2:0] cmd_sel;
  logic [4:0] cur_len;
  logic last_bit, wen_hold, cmd_done, wr_done, rd_done, stop_seen, resync;
  logic [7:0] status;
  logic [1:0] ch;
  logic [23:0] rd_value;

  assign rx_next = {rx_shift[22:0], din_sync};
  assign cmd_next = rx_next[7:0];
  assign cmd_kind = cmd_next[bam_pkg::CMD_KIND_HI:bam_pkg::CMD_KIND_LO];
  assign cmd_sel = cmd_next[bam_pkg::CMD_SEL_HI:bam_pkg::CMD_SEL_LO];
  assign cur_len = (state == bam_pkg::ST_CMD) ? bam_pkg::LEN_BYTE
                   : bam_pkg::xfer_len(sel, setup[bam_pkg::SETUP_WL_BIT]); // R7
  assign last_bit = 5'(bit_cnt + 5'h01) == cur_len;
  // a leading one in the enable position is held, not counted
  assign wen_hold = (state == bam_pkg::ST_CMD) && (bit_cnt == 5'h00) && din_sync;
  assign resync = rise && din_sync && (ones_cnt == 6'(bam_pkg::RESYNC_ONES - 6'h01)); // R14
  assign cmd_done = rise && !resync && (state == bam_pkg::ST_CMD) && last_bit; // R2
  assign wr_done = rise && !resync && (state == bam_pkg::ST_WRITE) && last_bit;
  assign rd_done = rise && !resync && (state == bam_pkg::ST_READ) && last_bit;
  // in continuous read the host may shift in a stop command
  assign stop_seen = rise && !resync && (state == bam_pkg::ST_READ) && cont && (bit_cnt == 5'h07)
                     && !cmd_next[bam_pkg::CMD_WEN_BIT] && (cmd_kind == bam_pkg::KIND_STOP); // R15
  assign ch = chan_idx(setup);
  assign status = {not_ready, step_unsettled_i, standby_flag_i, reference_missing_flag_i,
                   1'b0, setup[bam_pkg::SETUP_MD_HI:bam_pkg::SETUP_MD_LO]}; // R5

  // read data left-aligned so the first bit out is always bit 23
  function automatic logic [23:0] reg_view(input logic [2:0] s);
    case (s)
      bam_pkg::SEL_STATUS: reg_view = {status, 16'h0000}; // R2
      bam_pkg::SEL_RESULT: reg_view = result; // R6
      bam_pkg::SEL_SETUP: reg_view = {setup, 8'h00};
      bam_pkg::SEL_AVG: reg_view = avg;
      bam_pkg::SEL_TARE: reg_view = {tare, 16'h0000};
      bam_pkg::SEL_ZERO: reg_view = zero_coef[ch];
      bam_pkg::SEL_SCALE: reg_view = scale_coef[ch];
      default: reg_view = diag;
    endcase
  endfunction : reg_view

  logic [23:0] load_value;
  always_comb begin
    rd_value = reg_view(sel);
    load_value = reg_view(cmd_sel);
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ones_cnt <= 6'h00;
    end else if (resync || (rise && !din_sync)) begin
      ones_cnt <= 6'h00;
    end else if (rise) begin
      ones_cnt <= 6'(ones_cnt + 6'h01);
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state <= bam_pkg::ST_CMD; // R16
      sel <= bam_pkg::SEL_STATUS;
      cont <= 1'b0;
      bit_cnt <= 5'h00;
      rx_shift <= 24'h000000;
    end else if (resync) begin
      state <= bam_pkg::ST_CMD; // R14
      cont <= 1'b0;
      bit_cnt <= 5'h00;
    end else if (cs_n_sync) begin
      bit_cnt <= 5'h00;
    end else if (rise) begin
      rx_shift <= rx_next;
      bit_cnt <= (last_bit || stop_seen) ? 5'h00 : (wen_hold ? bit_cnt : 5'(bit_cnt + 5'h01));
      if (cmd_done) begin
        sel <= cmd_sel; // R3
        case (cmd_kind) // R15
          bam_pkg::KIND_WRITE: state <= (cmd_sel == bam_pkg::SEL_STATUS) ? bam_pkg::ST_CMD : bam_pkg::ST_WRITE;
          bam_pkg::KIND_READ: state <= bam_pkg::ST_READ;
          bam_pkg::KIND_CONT: begin
            state <= bam_pkg::ST_READ;
            cont <= 1'b1;
          end
          default: begin
            state <= bam_pkg::ST_CMD;
            cont <= 1'b0;
          end
        endcase
      end else if (stop_seen) begin
        state <= bam_pkg::ST_CMD;
        cont <= 1'b0;
      end else if (wr_done || (rd_done && !cont)) begin
        state <= bam_pkg::ST_CMD; // R4
      end
    end
  end

  // ************************************************************
  // serial output
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tx_shift <= 24'h000000;
      dout_o <= 1'b0;
      dout_oe_o <= 1'b0;
    end else begin
      dout_oe_o <= !cs_n_sync && (state == bam_pkg::ST_READ);
      if (cmd_done && (cmd_kind == bam_pkg::KIND_READ || cmd_kind == bam_pkg::KIND_CONT)) begin
        tx_shift <= load_value; // R3
        dout_o <= load_value[23];
      end else if (rd_done && cont) begin
        tx_shift <= rd_value; // R4
      end else if (rise) begin
        tx_shift <= {tx_shift[22:0], 1'b0};
      end else if (fall) begin
        dout_o <= tx_shift[23];
      end
    end
  end

  // ************************************************************
  // register file
  // ************************************************************
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setup <= bam_pkg::RST_SETUP; // R16
      avg <= bam_pkg::RST_AVG;
      tare <= bam_pkg::RST_TARE;
      diag <= bam_pkg::RST_DIAG;
      for (int i = 0; i < COEF_SETS; i++) begin
        zero_coef[i] <= bam_pkg::RST_ZERO;
        scale_coef[i] <= bam_pkg::RST_SCALE;
      end
    end else if (resync) begin
      setup <= bam_pkg::RST_SETUP; // R14
      avg <= bam_pkg::RST_AVG;
      tare <= bam_pkg::RST_TARE;
      diag <= bam_pkg::RST_DIAG;
      for (int i = 0; i < COEF_SETS; i++) begin
        zero_coef[i] <= bam_pkg::RST_ZERO;
        scale_coef[i] <= bam_pkg::RST_SCALE;
      end
    end else if (wr_done) begin
      case (sel)
        bam_pkg::SEL_SETUP: setup <= rx_next[15:0]; // R8
        bam_pkg::SEL_AVG: avg <= rx_next; // R9
        bam_pkg::SEL_TARE: tare <= rx_next[7:0] & bam_pkg::TARE_MASK; // R10
        bam_pkg::SEL_ZERO: zero_coef[ch] <= rx_next; // R11
        bam_pkg::SEL_SCALE: scale_coef[ch] <= rx_next; // R12
        bam_pkg::SEL_DIAG: diag <= rx_next;
        default: ;
      endcase
    end
  end

  // new data wins over the clear caused by reading the result
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      result <= bam_pkg::RST_RESULT; // R6
      not_ready <= 1'b1;
    end else begin
      if (result_load_i) begin
        result <= result_i; // R6
        not_ready <= 1'b0; // R5
      end else if (rd_done && sel == bam_pkg::SEL_RESULT) begin
        not_ready <= 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      setup_o <= bam_pkg::RST_SETUP;
      averaging_o <= bam_pkg::RST_AVG;
      tare_o <= bam_pkg::RST_TARE;
      zero_coef_o <= bam_pkg::RST_ZERO;
      scale_coef_o <= bam_pkg::RST_SCALE;
      diag_o <= bam_pkg::RST_DIAG;
    end else begin
      setup_o <= setup;
      averaging_o <= avg;
      tare_o <= tare;
      zero_coef_o <= zero_coef[ch]; // R11
      scale_coef_o <= scale_coef[ch]; // R12
      diag_o <= diag;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  logic boot;
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      boot <= 1'b1;
    end else begin
      boot <= 1'b0;
    end
  end

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  chk_cmd_to_read: assert property ( // R3
    cmd_done && cmd_kind == bam_pkg::KIND_READ |=> state == bam_pkg::ST_READ && sel == $past(cmd_sel))
    else $error("read command not taken");
  chk_cmd_to_write: assert property ( // R15
    cmd_done && cmd_kind == bam_pkg::KIND_WRITE && cmd_sel != bam_pkg::SEL_STATUS |=> state == bam_pkg::ST_WRITE)
    else $error("write command not taken");
  chk_single_return: assert property ( // R4
    (wr_done || (rd_done && !cont)) |=> state == bam_pkg::ST_CMD)
    else $error("single transfer did not return to command");
  chk_cont_stays: assert property ( // R4
    rd_done && cont |=> state == bam_pkg::ST_READ ##1 tx_shift == $past(rd_value, 2) || rise)
    else $error("continuous read left its register");
  chk_stop_read: assert property ( // R15
    cmd_done && cmd_kind == bam_pkg::KIND_STOP |=> !cont && state == bam_pkg::ST_CMD)
    else $error("stop command ignored");
  chk_result_len: assert property ( // R7
    state == bam_pkg::ST_READ && sel == bam_pkg::SEL_RESULT |->
    cur_len == (setup[bam_pkg::SETUP_WL_BIT] ? bam_pkg::LEN_WORD : bam_pkg::LEN_HALF))
    else $error("result length wrong");
  chk_tare_upper: assert property ( // R10
    (tare_o & ~bam_pkg::TARE_MASK) == 8'h00)
    else $error("tare upper bits set");
  chk_resync_clear: assert property ( // R14
    resync |=> state == bam_pkg::ST_CMD && setup == bam_pkg::RST_SETUP ##1 setup_o == bam_pkg::RST_SETUP)
    else $error("resync did not reset");
  chk_ready_flag: assert property ( // R5
    result_load_i |=> !not_ready && status[7] == 1'b0 && result == $past(result_i))
    else $error("new result not flagged");
  chk_reset_defaults: assert property ( // R16
    boot |-> state == bam_pkg::ST_CMD && setup_o == bam_pkg::RST_SETUP && averaging_o == bam_pkg::RST_AVG
    && tare_o == bam_pkg::RST_TARE && zero_coef_o == bam_pkg::RST_ZERO && result == bam_pkg::RST_RESULT)
    else $error("defaults missing after reset");

  cov_single_read: cover property (cmd_done && cmd_kind == bam_pkg::KIND_READ ##[1:200] rd_done);
  cov_cont_read: cover property (rd_done && cont ##[1:200] rd_done);
  cov_write_setup: cover property (wr_done && sel == bam_pkg::SEL_SETUP);
  cov_resync: cover property (resync);

endmodule : bam_register_map

// ---- logic/bam_pkg.sv ----
// constants, codes and helpers for the bridge converter register map
package bam_pkg;

  // ************************************************************
  // target selections carried in the command byte
  // ************************************************************
  localparam logic [2:0] SEL_STATUS = 3'h0;
  localparam logic [2:0] SEL_RESULT = 3'h1;
  localparam logic [2:0] SEL_SETUP = 3'h2;
  localparam logic [2:0] SEL_AVG = 3'h3;
  localparam logic [2:0] SEL_TARE = 3'h4;
  localparam logic [2:0] SEL_ZERO = 3'h5;
  localparam logic [2:0] SEL_SCALE = 3'h6;
  localparam logic [2:0] SEL_DIAG = 3'h7;

  // ************************************************************
  // transfer kinds and command byte layout
  // ************************************************************
  localparam logic [1:0] KIND_WRITE = 2'h0;
  localparam logic [1:0] KIND_READ = 2'h1;
  localparam logic [1:0] KIND_CONT = 2'h2;
  localparam logic [1:0] KIND_STOP = 2'h3;
  localparam int CMD_WEN_BIT = 7;
  localparam int CMD_KIND_HI = 5;
  localparam int CMD_KIND_LO = 4;
  localparam int CMD_SEL_HI = 2;
  localparam int CMD_SEL_LO = 0;

  // ************************************************************
  // reset values and field positions
  // ************************************************************
  localparam logic [15:0] RST_SETUP = 16'h01B0;
  localparam logic [23:0] RST_AVG = 24'h200010;
  localparam logic [7:0] RST_TARE = 8'h20;
  localparam logic [23:0] RST_ZERO = 24'h800000;
  localparam logic [23:0] RST_SCALE = 24'h59AEE7;
  localparam logic [23:0] RST_DIAG = 24'h000000;
  localparam logic [23:0] RST_RESULT = 24'h000000;
  localparam logic [7:0] TARE_MASK = 8'h3F;
  localparam int SETUP_WL_BIT = 8;
  localparam int SETUP_MD_HI = 15;
  localparam int SETUP_MD_LO = 13;
  localparam int SETUP_CH_HI = 1;
  localparam int SETUP_CH_LO = 0;

  // ************************************************************
  // transfer lengths and resync count
  // ************************************************************
  localparam logic [4:0] LEN_BYTE = 5'h08;
  localparam logic [4:0] LEN_HALF = 5'h10;
  localparam logic [4:0] LEN_WORD = 5'h18;
  localparam logic [5:0] RESYNC_ONES = 6'h20;

  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_WRITE = 3'b010,
    ST_READ = 3'b100
  } bam_state_e;

  // serial length of the selected register
  function automatic logic [4:0] xfer_len(input logic [2:0] sel, input logic wl);
    case (sel)
      SEL_STATUS, SEL_TARE: xfer_len = LEN_BYTE;
      SEL_SETUP: xfer_len = LEN_HALF;
      SEL_RESULT: xfer_len = wl ? LEN_WORD : LEN_HALF;
      default: xfer_len = LEN_WORD;
    endcase
  endfunction : xfer_len

endpackage : bam_pkg

// ---- tb/bam_host_model.sv ----
// host-side serial port model that drives clock, data and select of the register bank
module bam_host_model (
  input wire logic sys_clk_i,
  input wire logic miso_i,
  output logic sclk_o,
  output logic din_o,
  output logic cs_n_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // idle levels: clock high, select released
  // ************************************************************
  initial begin
    sclk_o = 1'b1;
    din_o = 1'b0;
    cs_n_o = 1'b1;
  end

  task automatic open_session();
    @(negedge sys_clk_i);
    cs_n_o = 1'b0;
    repeat (4) @(negedge sys_clk_i);
  endtask : open_session

  // ************************************************************
  // msb-first shift, left aligned both ways; every register is reached here only
  // ************************************************************
  task automatic shift(input logic [23:0] wv, input int n, output logic [23:0] rv);
    rv = 24'h000000;
    for (int i = 0; i < n; i++) begin
      sclk_o = 1'b0;
      din_o = wv[23-i];
      repeat (5) @(negedge sys_clk_i);
      rv[23-i] = miso_i;
      sclk_o = 1'b1;
      repeat (4) @(negedge sys_clk_i);
    end
    din_o = 1'b0;
  endtask : shift

  // every access starts with a command byte
  task automatic command(input logic [1:0] kind, input logic [2:0] sel);
    logic [23:0] junk;
    shift({1'b0, 1'b0, kind, 1'b0, sel, 16'h0000}, 8, junk);
  endtask : command

  // recovery after a lost sequence: 32 clocks with data high
  task automatic resync();
    logic [23:0] junk;
    shift(24'hFFFFFF, 24, junk);
    shift(24'hFF0000, 8, junk);
    repeat (8) @(negedge sys_clk_i);
  endtask : resync
endmodule : bam_host_model

// ---- tb/test_bam_register_map.sv ----
// self-checking bench of the serial register bank
module test_bam_register_map;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic sclk, din, cs_n, dout, dout_oe, dout_last, miso;
  logic [23:0] result = 24'h000000;
  logic result_load = 1'b0;
  logic step_unsettled = 1'b1;
  logic standby_flag = 1'b0;
  logic reference_missing_flag = 1'b0;
  logic [15:0] setup;
  logic [23:0] averaging, zero_coef, scale_coef, diag, rv;
  logic [7:0] tare;
  int n_errors = 0;
  int check_count = 0;
  int cycles = 0;
  logic [2:0] dsel [6] = '{3'h2, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
  int dlen [6] = '{16, 24, 8, 24, 24, 24};
  logic [23:0] dexp [6] = '{24'h01B000, 24'h200010, 24'h200000, 24'h800000, 24'h59AEE7, 24'h000000};

  always #4 sys_clk = ~sys_clk;

  // a released data line shows the inverse of its last driven level
  always_ff @(posedge sys_clk) if (dout_oe) dout_last <= dout;
  assign miso = dout_oe ? dout : ~dout_last;

  bam_register_map i_dut (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .sclk_i(sclk), .din_i(din), .cs_n_i(cs_n),
    .dout_o(dout), .dout_oe_o(dout_oe), .result_i(result), .result_load_i(result_load),
    .step_unsettled_i(step_unsettled), .standby_flag_i(standby_flag),
    .reference_missing_flag_i(reference_missing_flag), .setup_o(setup), .averaging_o(averaging),
    .tare_o(tare), .zero_coef_o(zero_coef), .scale_coef_o(scale_coef), .diag_o(diag)
  );

  bam_host_model i_host (.sys_clk_i(sys_clk), .miso_i(miso), .sclk_o(sclk), .din_o(din), .cs_n_o(cs_n));

  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic tally_and_finish();
    if (n_errors == 0 && check_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask : check

  task automatic access(input logic [1:0] kind, input logic [2:0] sel, input logic [23:0] wv, input int n,
                        output logic [23:0] r);
    i_host.command(kind, sel);
    i_host.shift(wv, n, r);
    if (kind == bam_pkg::KIND_WRITE) repeat (8) @(negedge sys_clk);
  endtask : access

  task automatic wr(input logic [2:0] sel, input logic [23:0] wv, input int n);
    logic [23:0] junk;
    access(bam_pkg::KIND_WRITE, sel, wv, n, junk);
  endtask : wr

  task automatic rd_check(input string name, input logic [2:0] sel, input int n, input logic [23:0] exp);
    logic [23:0] r;
    access(bam_pkg::KIND_READ, sel, 24'h000000, n, r);
    check(name, exp, r);
  endtask : rd_check

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      n_errors++;
      tally_and_finish();
    end
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (16) @(negedge sys_clk);
    reset_n = 1'b1;
    repeat (8) @(negedge sys_clk);
    check("copies", {8'h00, 16'h01B0}, {8'h00, setup});
    check("avg_copy", 24'h200010, averaging);
    check("tare_copy", 24'h000020, {16'h0000, tare});
    check("zero_copy", 24'h800000, zero_coef);
    check("scale_copy", 24'h59AEE7, scale_coef);
    check("diag_copy", 24'h000000, diag);
    check("oe_idle", 24'h000000, {23'h0, dout_oe});
    i_host.open_session();
    rd_check("status_rst", bam_pkg::SEL_STATUS, 8, 24'hC00000);
    rd_check("result_rst", bam_pkg::SEL_RESULT, 24, 24'h000000);
    for (int i = 0; i < 6; i++) rd_check("default", dsel[i], dlen[i], dexp[i]);
    @(negedge sys_clk);
    result = 24'hABCDEF;
    result_load = 1'b1;
    @(negedge sys_clk);
    result_load = 1'b0;
    rd_check("status_ready", bam_pkg::SEL_STATUS, 8, 24'h400000);
    rd_check("result24", bam_pkg::SEL_RESULT, 24, 24'hABCDEF);
    rd_check("status_drained", bam_pkg::SEL_STATUS, 8, 24'hC00000);
    // leading ones are held until the enable bit is zero
    i_host.shift(24'hE00000, 3, rv);
    wr(bam_pkg::SEL_SETUP, 24'h000100, 16);
    check("setup_copy", 24'h000001, {8'h00, setup});
    rd_check("result16", bam_pkg::SEL_RESULT, 16, 24'hABCD00);
    wr(bam_pkg::SEL_STATUS, 24'h000000, 0);
    wr(bam_pkg::SEL_RESULT, 24'h123400, 16);
    rd_check("result_ro", bam_pkg::SEL_RESULT, 16, 24'hABCD00);
    wr(bam_pkg::SEL_ZERO, 24'h111111, 24);
    wr(bam_pkg::SEL_SCALE, 24'h222222, 24);
    check("zero_ch1", 24'h111111, zero_coef);
    check("scale_ch1", 24'h222222, scale_coef);
    wr(bam_pkg::SEL_SETUP, 24'h000200, 16);
    check("zero_ch2", 24'h800000, zero_coef);
    check("scale_ch2", 24'h59AEE7, scale_coef);
    wr(bam_pkg::SEL_SETUP, 24'h000100, 16);
    rd_check("zero_rd", bam_pkg::SEL_ZERO, 24, 24'h111111);
    rd_check("scale_rd", bam_pkg::SEL_SCALE, 24, 24'h222222);
    wr(bam_pkg::SEL_TARE, 24'hFF0000, 8);
    check("tare_masked", 24'h00003F, {16'h0000, tare});
    rd_check("tare_rd", bam_pkg::SEL_TARE, 8, 24'h3F0000);
    wr(bam_pkg::SEL_AVG, 24'h123456, 24);
    check("avg_copy_wr", 24'h123456, averaging);
    rd_check("avg_rd", bam_pkg::SEL_AVG, 24, 24'h123456);
    i_host.command(bam_pkg::KIND_CONT, bam_pkg::SEL_RESULT);
    for (int i = 0; i < 2; i++) begin
      i_host.shift(24'h000000, 16, rv);
      check("cont_word", 24'hABCD00, rv);
    end
    i_host.shift(24'h300000, 8, rv);
    rd_check("after_stop", bam_pkg::SEL_TARE, 8, 24'h3F0000);
    wr(bam_pkg::SEL_SETUP, 24'hA00100, 16);
    i_host.command(bam_pkg::KIND_STOP, bam_pkg::SEL_STATUS);
    step_unsettled = 1'b0;
    standby_flag = 1'b1;
    reference_missing_flag = 1'b1;
    rd_check("status_flags", bam_pkg::SEL_STATUS, 8, 24'hB50000);
    i_host.command(bam_pkg::KIND_WRITE, bam_pkg::SEL_AVG);
    i_host.shift(24'h000000, 5, rv);
    i_host.resync();
    check("resync_setup", 24'h0001B0, {8'h00, setup});
    check("resync_tare", 24'h000020, {16'h0000, tare});
    check("resync_zero", 24'h800000, zero_coef);
    rd_check("resync_avg", bam_pkg::SEL_AVG, 24, 24'h200010);
    rd_check("resync_result", bam_pkg::SEL_RESULT, 24, 24'hABCDEF);
    tally_and_finish();
  end
endmodule : test_bam_register_map
